// ==== verilog/gpio_cmd_pkg.sv ====
/*
 * Constants, register map and state type for the pin command interpreter.
 * Assumes one 25 MHz clock domain; imported by the interpreter top, the checker and the testbench.
 */
package gpio_cmd_pkg;

    // ------------------------------------------------------------------
    // Frame and pin geometry
    // ------------------------------------------------------------------
    localparam int PIN_N = 11;
    localparam int VEC_W = 32;
    localparam int FRAME_LEN = 9;
    localparam int RESP_LEN = 5;
    localparam int ERR_LEN = 1;

    // ------------------------------------------------------------------
    // Command codes
    // ------------------------------------------------------------------
    localparam logic [7:0] CMD_GET_FUNC = 8'h10;
    localparam logic [7:0] CMD_GET_DIR = 8'h11;
    localparam logic [7:0] CMD_GET_LVL = 8'h12;
    localparam logic [7:0] CMD_GET_STATE = 8'h13;
    localparam logic [7:0] CMD_SET_DIR = 8'h19;
    localparam logic [7:0] CMD_SET_LVL = 8'h1a;
    localparam logic [7:0] CMD_SET_STATE = 8'h1b;
    localparam logic [7:0] ERR_BYTE = 8'hff;

    // ------------------------------------------------------------------
    // Register map (byte addresses) and fields
    // ------------------------------------------------------------------
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_FUNC = 8'h04;
    localparam logic [7:0] REG_BOOT_DIR = 8'h08;
    localparam logic [7:0] REG_BOOT_LVL = 8'h0c;
    localparam logic [7:0] REG_DIR = 8'h10;
    localparam logic [7:0] REG_LVL = 8'h14;
    localparam logic [7:0] REG_STATE = 8'h18;
    localparam logic [7:0] REG_STAT = 8'h1c;
    localparam int CTRL_DIS_BIT = 0;
    localparam int CTRL_RELOAD_BIT = 1;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_DIS_BIT = 1;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [PIN_N-1:0] FUNC_RST = 11'h7ff;
    localparam logic [PIN_N-1:0] DIR_RST = 11'h000;
    localparam logic [PIN_N-1:0] LVL_RST = 11'h7ff;
    localparam logic [PIN_N-1:0] STATE_RST = 11'h000;

    typedef enum logic [1:0]
    {
        S_RX = 2'b00,
        S_EXEC = 2'b01,
        S_TX = 2'b10
    } cmd_state_t;

endpackage

// ==== verilog/gpio_cmd_interp.sv ====
/*
 * Pin command interpreter: collects nine-byte request frames from a byte
 * stream, executes them on eleven general purpose pins and streams back
 * the answer. Assumes a network stack on the same clock that feeds and
 * drains bytes with valid/ready, a software master on the register port,
 * and pins that arrive asynchronously.
 */
// Added by the designer: the address map and the plain strobed port.
// Overview of operation
// - Request frame is nine bytes
// - Parameters are little-endian 32-bit pin vectors
// - Non-general pins: reads undefined, writes ignored
// - Valid command answered with five bytes
// - Unknown command answered with single 0FFh
// - Decode the seven command codes
// - No command changes pin function
// - Written settings are volatile only
// - Read functions: 1 means general purpose
// - Read directions: 1 output, 0 input
// - Read levels: 1 low-active, 0 high-active
// - Read states: 1 means pin active
// - Write directions under mask, return result
// - Direction value 1 output, 0 input
// - Parameter bytes ignored but always consumed
// - Boot loads direction and level defaults
// - Eleven pins implemented, bits 0-10
// - Option disables whole command interface
// - Write levels under mask, return result
// - Write states under mask, return result
`timescale 1ns/1ns
`default_nettype none

module gpio_cmd_interp
    import gpio_cmd_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    output logic rx_ready,
    output logic tx_valid,
    output logic [7:0] tx_data,
    input wire logic tx_ready,
    input wire logic [PIN_N-1:0] gpio_i,
    output logic [PIN_N-1:0] gpio_o,
    output logic [PIN_N-1:0] gpio_oe_n
);

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [7:0] vec_byte(input logic [VEC_W-1:0] vec,
                                            input logic [2:0] idx);
        logic [7:0] res;
        res = 8'h00;
        case (idx)
            3'h0: res = vec[7:0];
            3'h1: res = vec[15:8];
            3'h2: res = vec[23:16];
            3'h3: res = vec[31:24];
            default: res = 8'h00;
        endcase
        return res;
    endfunction

    function automatic logic [PIN_N-1:0] masked_upd(input logic [PIN_N-1:0] old,
                                                    input logic [PIN_N-1:0] val,
                                                    input logic [PIN_N-1:0] msk);
        return (old & ~msk) | (val & msk);
    endfunction

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    cmd_state_t state_ff;
    cmd_state_t nxt_state;
    logic [3:0] rx_idx_ff;
    logic [3:0] nxt_rx_idx;
    logic [7:0] frame_ff [FRAME_LEN];
    logic rx_ready_ff;
    logic tx_valid_ff;
    logic [7:0] tx_data_ff;
    logic [2:0] tx_idx_ff;
    logic [2:0] tx_len_ff;
    logic [VEC_W-1:0] resp_vec_ff;
    logic [31:0] rdata_ff;
    logic dis_ff;
    logic [PIN_N-1:0] func_ff;
    logic [PIN_N-1:0] boot_dir_ff;
    logic [PIN_N-1:0] boot_lvl_ff;
    logic [PIN_N-1:0] dir_ff;
    logic [PIN_N-1:0] lvl_ff;
    logic [PIN_N-1:0] pin_state_ff;
    logic [PIN_N-1:0] pin_meta_ff;
    logic [PIN_N-1:0] pin_sync_ff;
    logic [PIN_N-1:0] gpio_o_ff;
    logic [PIN_N-1:0] gpio_oe_n_ff;
    logic [PIN_N-1:0] pin_now;

    // ------------------------------------------------------------------
    // Register port decode
    // ------------------------------------------------------------------
    wire wr_ctrl = reg_wr && (reg_addr == REG_CTRL);
    wire wr_func = reg_wr && (reg_addr == REG_FUNC);
    wire wr_boot_dir = reg_wr && (reg_addr == REG_BOOT_DIR);
    wire wr_boot_lvl = reg_wr && (reg_addr == REG_BOOT_LVL);
    // A reload stands for a reboot: every volatile change is dropped.
    // volatile restore
    wire reload = wr_ctrl && reg_wdata[CTRL_RELOAD_BIT];
    // Busy covers a partly collected frame as well as execution and answer.
    wire busy = (state_ff != S_RX) || (rx_idx_ff != 4'h0);
    wire [31:0] stat_word = {30'h0, dis_ff, busy};
    wire [31:0] rd_word =
        (reg_addr == REG_CTRL) ? {31'h0, dis_ff} :
        (reg_addr == REG_FUNC) ? {21'h0, func_ff} :
        (reg_addr == REG_BOOT_DIR) ? {21'h0, boot_dir_ff} :
        (reg_addr == REG_BOOT_LVL) ? {21'h0, boot_lvl_ff} :
        (reg_addr == REG_DIR) ? {21'h0, dir_ff} :
        (reg_addr == REG_LVL) ? {21'h0, lvl_ff} :
        (reg_addr == REG_STATE) ? {21'h0, pin_now} :
        (reg_addr == REG_STAT) ? stat_word : 32'h0;

    // ------------------------------------------------------------------
    // Frame collection
    // ------------------------------------------------------------------
    wire rx_take = rx_valid && rx_ready_ff;
    wire last_byte = rx_idx_ff == 4'(FRAME_LEN - 1);

    // Bytes that arrive while disabled are drained rather than stalled, so a
    // closed interface cannot back up the network stack.
    generate
        for (genvar i = 0; i < FRAME_LEN; i++)
        begin : g_frame
            always_ff @(posedge ref_clk or negedge rstn)
            begin
                if (!rstn)
                    frame_ff[i] <= 8'h00;
                else if (rx_take && !dis_ff && rx_idx_ff == 4'(i))
                    frame_ff[i] <= rx_data;
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // Command decode and execution
    // ------------------------------------------------------------------
    wire [7:0] cmd = frame_ff[0];
    wire [VEC_W-1:0] par1 = {frame_ff[4], frame_ff[3], frame_ff[2], frame_ff[1]};
    wire [VEC_W-1:0] par2 = {frame_ff[8], frame_ff[7], frame_ff[6], frame_ff[5]};
    wire [PIN_N-1:0] eff_mask = par1[PIN_N-1:0] & func_ff;
    wire [PIN_N-1:0] eff_val = par2[PIN_N-1:0];
    wire exec = state_ff == S_EXEC;
    wire is_set_dir = cmd == CMD_SET_DIR;
    wire is_set_lvl = cmd == CMD_SET_LVL;
    wire is_set_state = cmd == CMD_SET_STATE;
    wire cmd_ok = (cmd == CMD_GET_FUNC) || (cmd == CMD_GET_DIR)
        || (cmd == CMD_GET_LVL) || (cmd == CMD_GET_STATE)
        || is_set_dir || is_set_lvl || is_set_state;
    wire [PIN_N-1:0] dir_upd = masked_upd(dir_ff, eff_val, eff_mask);
    wire [PIN_N-1:0] lvl_upd = masked_upd(lvl_ff, eff_val, eff_mask);
    wire [PIN_N-1:0] state_upd = masked_upd(pin_state_ff, eff_val, eff_mask);
    // Output pins report the last written state, not the pad, so a heavily
    // loaded output still reads back what software asked for.
    // active means level matches polarity
    assign pin_now = (dir_ff & pin_state_ff) | (~dir_ff & (pin_sync_ff ^ lvl_ff));
    wire [PIN_N-1:0] ans_vec =
        (cmd == CMD_GET_FUNC) ? func_ff :
        (cmd == CMD_GET_DIR) ? dir_ff :
        (cmd == CMD_GET_LVL) ? lvl_ff :
        (cmd == CMD_GET_STATE) ? pin_now :
        is_set_dir ? dir_upd :
        is_set_lvl ? lvl_upd :
        is_set_state ? state_upd : {PIN_N{1'b0}};

    // ------------------------------------------------------------------
    // Sequencing
    // ------------------------------------------------------------------
    // The answer length is latched at execution, so the answer cannot be
    // stretched or cut by anything that happens while it drains.
    wire tx_take = tx_valid_ff && tx_ready;
    wire tx_done = tx_take && (tx_idx_ff + 3'h1 == tx_len_ff);

    always_comb
    begin
        nxt_state = state_ff;
        nxt_rx_idx = rx_idx_ff;
        case (state_ff)
            S_RX:
            begin
                if (dis_ff)
                    nxt_rx_idx = 4'h0;
                else if (rx_take && last_byte)
                begin
                    nxt_rx_idx = 4'h0;
                    nxt_state = S_EXEC;
                end
                else if (rx_take)
                    nxt_rx_idx = rx_idx_ff + 4'h1;
            end
            S_EXEC:
                nxt_state = S_TX;
            S_TX:
            begin
                if (tx_done)
                    nxt_state = S_RX;
            end
            default:
            begin
                nxt_state = S_RX;
                nxt_rx_idx = 4'h0;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state_ff <= S_RX;
            rx_idx_ff <= 4'h0;
            rx_ready_ff <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            rx_idx_ff <= nxt_rx_idx;
            // The input reopens only after the last answer byte has gone,
            // so a host that breaks the wait rule cannot overlap frames.
            rx_ready_ff <= nxt_state == S_RX;
        end
    end

    // ------------------------------------------------------------------
    // Answer stream
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            tx_valid_ff <= 1'b0;
            tx_data_ff <= 8'h00;
            tx_idx_ff <= 3'h0;
            tx_len_ff <= 3'h0;
            resp_vec_ff <= 32'h0;
        end
        else if (exec)
        begin
            tx_valid_ff <= 1'b1;
            tx_idx_ff <= 3'h0;
            // The vector is frozen here; later pin changes do not alter bytes
            // that are still waiting for the sink.
            resp_vec_ff <= {21'h0, ans_vec};
            tx_data_ff <= cmd_ok ? cmd : ERR_BYTE;
            tx_len_ff <= cmd_ok ? 3'(RESP_LEN) : 3'(ERR_LEN);
        end
        else if (tx_done)
            tx_valid_ff <= 1'b0;
        else if (tx_take)
        begin
            tx_idx_ff <= tx_idx_ff + 3'h1;
            tx_data_ff <= vec_byte(resp_vec_ff, tx_idx_ff);
        end
    end

    // ------------------------------------------------------------------
    // Configuration and volatile pin state
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            dis_ff <= 1'b0;
            func_ff <= FUNC_RST;
            boot_dir_ff <= DIR_RST;
            boot_lvl_ff <= LVL_RST;
        end
        else
        begin
            if (wr_ctrl)
                dis_ff <= reg_wdata[CTRL_DIS_BIT];
            if (wr_func)
                func_ff <= reg_wdata[PIN_N-1:0];
            if (wr_boot_dir)
                boot_dir_ff <= reg_wdata[PIN_N-1:0];
            if (wr_boot_lvl)
                boot_lvl_ff <= reg_wdata[PIN_N-1:0];
        end
    end

    // Boot values win over a command executing in the same cycle.
    // boot defaults load
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            dir_ff <= DIR_RST;
            lvl_ff <= LVL_RST;
            pin_state_ff <= STATE_RST;
        end
        else if (reload)
        begin
            dir_ff <= boot_dir_ff;
            lvl_ff <= boot_lvl_ff;
            pin_state_ff <= STATE_RST;
        end
        else if (exec)
        begin
            if (is_set_dir)
                dir_ff <= dir_upd;
            if (is_set_lvl)
                lvl_ff <= lvl_upd;
            if (is_set_state)
                pin_state_ff <= state_upd;
        end
    end

    // ------------------------------------------------------------------
    // Pins and read port
    // ------------------------------------------------------------------
    // Pins with a dedicated function are never driven from here.
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            pin_meta_ff <= {PIN_N{1'b0}};
            pin_sync_ff <= {PIN_N{1'b0}};
            gpio_o_ff <= {PIN_N{1'b0}};
            gpio_oe_n_ff <= {PIN_N{1'b1}};
            rdata_ff <= 32'h0;
        end
        else
        begin
            // Only the second synchroniser stage is read by any logic.
            pin_meta_ff <= gpio_i;
            pin_sync_ff <= pin_meta_ff;
            gpio_o_ff <= pin_state_ff ^ lvl_ff;
            gpio_oe_n_ff <= ~(dir_ff & func_ff);
            // Read data fall back to zero after one cycle, so a stale word is
            // never taken for a fresh one.
            if (reg_rd)
                rdata_ff <= rd_word;
            else
                rdata_ff <= 32'h0;
        end
    end

    assign reg_rdata = rdata_ff;
    assign rx_ready = rx_ready_ff;
    assign tx_valid = tx_valid_ff;
    assign tx_data = tx_data_ff;
    assign gpio_o = gpio_o_ff;
    assign gpio_oe_n = gpio_oe_n_ff;

endmodule

`default_nettype wire

// ==== dv/gpio_cmd_interp_chk.sv ====
/*
 * Concurrent checks on the byte link of the pin command interpreter.
 * Assumes it is bound to the interpreter top and shares its single clock.
 */
`timescale 1ns/1ns
`default_nettype none

module gpio_cmd_interp_chk
    import gpio_cmd_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    input wire logic rx_ready,
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    input wire logic tx_ready
);
    // ------------------------------------------------------------------
    // Frame tracking
    // ------------------------------------------------------------------
    // The disable bit is mirrored from the register port because dropped
    // bytes would otherwise throw the byte count out of step.
    logic [3:0] cnt_ff;
    logic [2:0] ocnt_ff;
    logic [7:0] code_ff;
    logic dis_ff;
    wire take = rx_valid && rx_ready;
    wire put = tx_valid && tx_ready;
    wire last = take && cnt_ff == 4'h8 && !dis_ff;
    wire known = code_ff inside {CMD_GET_FUNC, CMD_GET_DIR, CMD_GET_LVL, CMD_GET_STATE,
        CMD_SET_DIR, CMD_SET_LVL, CMD_SET_STATE};
    wire [3:0] nxt_cnt = (dis_ff || last) ? 4'h0 : cnt_ff + {3'h0, take};
    wire [2:0] nxt_ocnt = take ? 3'h0 : ocnt_ff + {2'h0, put};
    wire [7:0] nxt_code = (take && cnt_ff == 4'h0) ? rx_data : code_ff;
    wire nxt_dis = (reg_wr && reg_addr == REG_CTRL) ? reg_wdata[CTRL_DIS_BIT] : dis_ff;

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            cnt_ff <= 4'h0;
            ocnt_ff <= 3'h0;
            code_ff <= 8'h00;
            dis_ff <= 1'b0;
        end
        else
        begin
            cnt_ff <= nxt_cnt;
            ocnt_ff <= nxt_ocnt;
            code_ff <= nxt_code;
            dis_ff <= nxt_dis;
        end
    end

    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rstn);

    property p_take_last;
        last |=> !rx_ready;
    endproperty
    a_take_last: assert property (p_take_last)
        else $error("input still open after ninth byte");
    property p_first_ans;
        last |-> ##2 tx_valid && tx_data == (known ? code_ff : ERR_BYTE);
    endproperty
    a_first_ans: assert property (p_first_ans)
        else $error("first answer byte wrong or late");
    property p_no_early;
        $rose(tx_valid) |-> !rx_ready && $past(!rx_ready);
    endproperty
    a_no_early: assert property (p_no_early)
        else $error("answer started before frame closed");
    property p_hold;
        tx_valid && !tx_ready |=> tx_valid && $stable(tx_data);
    endproperty
    a_hold: assert property (p_hold)
        else $error("answer byte changed while stalled");
    property p_err_end;
        put && ocnt_ff == 3'h0 && tx_data == ERR_BYTE |=> !tx_valid && rx_ready;
    endproperty
    a_err_end: assert property (p_err_end)
        else $error("error answer longer than one byte");
    property p_five;
        put && ocnt_ff == 3'h4 |=> !tx_valid && rx_ready;
    endproperty
    a_five: assert property (p_five)
        else $error("answer not ended after five bytes");
    property p_rx_shut;
        tx_valid |-> !rx_ready;
    endproperty
    a_rx_shut: assert property (p_rx_shut)
        else $error("input open during answer");
    property p_high_zero;
        tx_valid && ocnt_ff >= 3'h2 |-> (tx_data & (ocnt_ff == 3'h2 ? 8'hf8 : 8'hff)) == 8'h00;
    endproperty
    a_high_zero: assert property (p_high_zero)
        else $error("unimplemented vector bits set");
    property p_dis_mute;
        $rose(tx_valid) |-> !dis_ff;
    endproperty
    a_dis_mute: assert property (p_dis_mute)
        else $error("answer while interface disabled");

    c_err: cover property (put && ocnt_ff == 3'h0 && tx_data == ERR_BYTE);
    c_stall: cover property (tx_valid && !tx_ready);
    c_dis: cover property (take && dis_ff);
endmodule

bind gpio_cmd_interp gpio_cmd_interp_chk chk (.ref_clk, .rstn, .reg_addr, .reg_wdata,
    .reg_wr, .rx_valid, .rx_data, .rx_ready, .tx_valid, .tx_data, .tx_ready);

`default_nettype wire

// ==== dv/gpio_host_model.sv ====
/*
 * Behavioural remote host: sends one request frame and gathers the answer.
 * Assumes it is called right after a rising edge of the interpreter clock.
 */
`timescale 1ns/1ns
`default_nettype none

module gpio_host_model
(
    input wire logic ref_clk,
    output logic rx_valid,
    output logic [7:0] rx_data,
    input wire logic rx_ready,
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    output logic tx_ready
);
    initial
    begin
        rx_valid = 1'b0;
        rx_data = 8'ha5;
        tx_ready = 1'b0;
    end

    task automatic xfer(input logic [7:0] code, input logic [31:0] p1, input logic [31:0] p2,
        input bit slow, output int n, output logic [7:0] echo, output logic [31:0] vec);
        logic [71:0] frame;
        int i;
        int t;
        bit done;
        frame = {p2, p1, code};
        n = 0;
        echo = 8'h00;
        vec = 32'h0;
        done = 1'b0;
        // Whole frame, least significant byte first.
        for (i = 0; i < 9; i++)
        begin
            rx_valid <= 1'b1;
            rx_data <= frame[8*i +: 8];
            t = 0;
            do
            begin
                @(posedge ref_clk);
                t++;
            end
            while (!rx_ready && t < 50);
        end
        // A released line shows the inverse so stale data cannot pass.
        rx_valid <= 1'b0;
        rx_data <= ~frame[71:64];
        tx_ready <= 1'b1;
        // Wait up to 40 cycles for the complete answer before returning.
        for (t = 0; t < 40 && !done; t++)
        begin
            @(posedge ref_clk);
            if (tx_valid && tx_ready)
            begin
                if (n == 0)
                    echo = tx_data;
                else
                    vec[8*(n-1) +: 8] = tx_data;
                n++;
            end
            done = n == 5 || (n == 1 && echo == 8'hff);
            tx_ready <= (done || t == 39) ? 1'b0 : (slow ? ~tx_ready : 1'b1);
        end
    endtask
endmodule

`default_nettype wire

// ==== dv/test_gpio_cmd_interp.sv ====
/*
 * Testbench for the pin command interpreter: register port tasks, a host
 * model on the byte link and pin stimulus. Assumes the checker is bound.
 */
`timescale 1ns/1ns
`default_nettype none

module test_gpio_cmd_interp
    import gpio_cmd_pkg::*;
;
    logic ref_clk, rstn, reg_wr, reg_rd, rx_valid, rx_ready, tx_valid, tx_ready;
    logic [7:0] reg_addr, rx_data, tx_data;
    logic [31:0] reg_wdata, reg_rdata, d;
    logic [PIN_N-1:0] gpio_i, gpio_o, gpio_oe_n, func_m, dir_m, lvl_m, st_m;
    int n_fail, comparisons, n, i;
    logic [7:0] e;
    logic [7:0] ra [7] = '{REG_FUNC, REG_BOOT_DIR, REG_BOOT_LVL, REG_DIR, REG_LVL, REG_STAT, 8'h20};
    logic [31:0] rv [7] = '{32'h7ff, 32'h0, 32'h7ff, 32'h0, 32'h7ff, 32'h0, 32'h0};
    logic [7:0] bad [5] = '{8'h00, 8'h14, 8'h18, 8'h1c, 8'hff};

    gpio_cmd_interp dut (.ref_clk(ref_clk), .rstn(rstn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready), .tx_valid(tx_valid),
        .tx_data(tx_data), .tx_ready(tx_ready), .gpio_i(gpio_i), .gpio_o(gpio_o),
        .gpio_oe_n(gpio_oe_n));
    gpio_host_model host (.ref_clk(ref_clk), .rx_valid(rx_valid), .rx_data(rx_data),
        .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready));

    always #20 ref_clk = ~ref_clk;

    // ------------------------------------------------------------------
    // Access tasks
    // ------------------------------------------------------------------
    task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic reg_write(input logic [7:0] a, input logic [31:0] v);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic reg_read(input logic [7:0] a, output logic [31:0] v);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(negedge ref_clk);
        v = reg_rdata;
    endtask

    task automatic run(input logic [7:0] code, input logic [31:0] p1, input logic [31:0] p2,
        input bit slow, input logic [31:0] exp, input logic [31:0] msk);
        int k;
        logic [7:0] c;
        logic [31:0] v;
        bit ok;
        ok = code inside {CMD_GET_FUNC, CMD_GET_DIR, CMD_GET_LVL, CMD_GET_STATE,
            CMD_SET_DIR, CMD_SET_LVL, CMD_SET_STATE};
        host.xfer(code, p1, p2, slow, k, c, v);
        cmp("answer code", ok ? {24'h0, code} : {24'h0, ERR_BYTE}, {24'h0, c});
        cmp("answer length", ok ? 32'd5 : 32'd1, k);
        if (ok)
            cmp("answer vector", exp & msk, v & msk);
    endtask

    function automatic logic [31:0] st_exp();
        return {21'h0, func_m & ((dir_m & st_m) | (~dir_m & (gpio_i ^ lvl_m)))};
    endfunction

    task automatic end_of_test();
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial
    begin
        repeat (10000) @(posedge ref_clk);
        n_fail++;
        end_of_test();
    end

    // ------------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------------
    initial
    begin
        {ref_clk, rstn, reg_wr, reg_rd, reg_addr, reg_wdata, gpio_i} = '0;
        {n_fail, comparisons} = '0;
        repeat (2) @(posedge ref_clk);
        rstn <= 1'b1;
        repeat (2) @(posedge ref_clk);
        for (i = 0; i < 7; i++)
        begin
            reg_read(ra[i], d);
            cmp("reset register", rv[i], d);
        end
        // Function mask comes only from the setup path.
        reg_write(REG_FUNC, 32'h203);
        func_m = 11'h203;
        run(CMD_GET_FUNC, 32'hdeadbeef, 32'h12345678, 0, 32'h203, '1);
        run(CMD_SET_DIR, 32'hffffffff, 32'h403, 1, 32'h3, func_m);
        {dir_m, lvl_m, st_m} = {11'h003, 11'h7ff, 11'h000};
        repeat (3) @(posedge ref_clk);
        cmp("pin enables", 32'h7fc, {21'h0, gpio_oe_n});
        reg_read(REG_DIR, d);
        cmp("direction register", 32'h3, d);
        run(CMD_GET_DIR, 32'hffffffff, 32'h0, 0, 32'h3, func_m);
        run(CMD_SET_LVL, 32'h1, 32'h0, 1, 32'h7fe, func_m);
        lvl_m = 11'h7fe;
        run(CMD_GET_LVL, 32'h0, 32'h0, 0, 32'h7fe, func_m);
        st_m = 11'h001;
        run(CMD_SET_STATE, 32'h203, 32'h1, 0, {21'h0, st_m}, func_m);
        repeat (3) @(posedge ref_clk);
        cmp("pin levels", 32'h3, {30'h0, gpio_o[1:0]});
        gpio_i <= 11'h200;
        repeat (5) @(posedge ref_clk);
        run(CMD_GET_STATE, 32'h0, 32'h0, 1, st_exp(), func_m);
        for (i = 0; i < 5; i++)
            run(bad[i], 32'h0, 32'h0, i[0], 32'h0, 32'h0);
        reg_write(REG_CTRL, 32'h1);
        reg_read(REG_STAT, d);
        cmp("status disable", 32'h2, d);
        host.xfer(CMD_GET_DIR, 32'h0, 32'h0, 0, n, e, d);
        cmp("answer while disabled", 32'd0, n);
        reg_write(REG_CTRL, 32'h0);
        run(CMD_GET_DIR, 32'h0, 32'h0, 0, 32'h3, func_m);
        reg_write(REG_BOOT_DIR, 32'h1);
        reg_write(REG_CTRL, 32'h2);
        run(CMD_GET_DIR, 32'h0, 32'h0, 0, 32'h1, func_m);
        run(CMD_GET_LVL, 32'h0, 32'h0, 0, 32'h7ff, func_m);
        reg_read(REG_DIR, d);
        cmp("direction after reload", 32'h1, d);
        reg_read(REG_FUNC, d);
        cmp("function after commands", 32'h203, d);
        end_of_test();
    end
endmodule

`default_nettype wire
